// [hdl/cycle_timer.sv]
// loadable down counter that flags when a wait has elapsed
`timescale 1ns/10ps
module cycle_timer
   import sram_host_pkg::*;
#(
   parameter int WIDTH = CNT_W
)
(
   // clock and reset
   input  wire logic             clock,
   input  wire logic             reset,
   // load and status
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] count,
   output logic                  done
);
   logic [WIDTH-1:0] remaining;
   wire  [WIDTH-1:0] next_remaining = load ? count :
                                      (remaining != '0) ? remaining - 1'b1 : remaining;

   // done is registered so the pin sequence reacts one edge after expiry
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         remaining <= '0;
         done      <= 1'b0;
      end
      else
      begin
         remaining <= next_remaining;
         done      <= !load && (next_remaining == '0);
      end
   end
endmodule

// [hdl/sram_host.sv]
// host controller sequencing the pins of a 2M x 8 asynchronous static memory
// Functional notes
// - write: selects on, write enable low
// - read: selects on, output enable low
// - data stable 5.5 ns before write end
// - wait 100 us before first access
// - read cycle at least 10 ns
// - write pulse 7 ns, cycle 10 ns
// - address valid by write start, held
// - write cycle covers turnoff plus setup
`timescale 1ns/10ps
module sram_host
   import sram_host_pkg::*;
#(
   parameter int FIRST_WAIT = FIRST_ACCESS_WAIT_CYCLES
)
(
   // clock and reset
   input  wire logic              clock,
   input  wire logic              reset,
   // user request side
   input  wire logic              req_valid,
   input  wire request_t          req,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_data,
   output logic                   init_done,
   // memory pins
   output logic [ADDR_W-1:0]      location_lines,
   output pins_t                  pins,
   output logic [DATA_W-1:0]      byte_lines_out,
   output logic                   byte_lines_oe_n,
   input  wire logic [DATA_W-1:0] byte_lines_in
);
   // the shared timer cannot hold a longer power-up wait
   if (FIRST_WAIT < 1 || FIRST_WAIT >= (1 << CNT_W))
   begin
      $error("FIRST_WAIT out of range");
   end

   typedef enum logic [6:0] {
      S_POWER   = 7'b000_0001,
      S_IDLE    = 7'b000_0010,
      S_RD_SET  = 7'b000_0100,
      S_RD_WAIT = 7'b000_1000,
      S_WR_SET  = 7'b001_0000,
      S_WR_PULS = 7'b010_0000,
      S_WR_END  = 7'b100_0000
   } state_t;

   state_t           state;
   state_t           next_state;
   logic             timer_load;
   logic [CNT_W-1:0] timer_count;
   logic             timer_done;
   logic [DATA_W-1:0] sync_a;
   logic [DATA_W-1:0] sync_b;
   logic             power_arm;

   // every wait in the sequence shares one timer, loaded on state entry
   cycle_timer #(.WIDTH(CNT_W)) u_timer
   (
      .clock (clock),
      .reset (reset),
      .load  (timer_load),
      .count (timer_count),
      .done  (timer_done)
   );

   wire take     = (state == S_IDLE) && req_valid;
   wire wait_end = timer_done && !timer_load;
   wire [CNT_W-1:0] wr_total = CNT_W'(TURNAROUND_CYCLES > CYCLE_MIN_CYCLES ?
                                       TURNAROUND_CYCLES : CYCLE_MIN_CYCLES);

   // next state and timer loading; a load masks the stale done of the last wait
   always_comb
   begin
      next_state  = state;
      timer_load  = 1'b0;
      timer_count = CNT_ONE;
      unique case (state)
         S_POWER:
         begin
            // full wait loaded on the first edge out of reset, else it ends at once
            timer_load  = power_arm;
            timer_count = CNT_W'(FIRST_WAIT);
            if (wait_end)
               next_state = S_IDLE;
         end
         S_IDLE:
            if (take)
            begin
               next_state = req.write ? S_WR_SET : S_RD_SET;
               timer_load = 1'b1;
            end
         S_RD_SET:
         begin
            // bus already released one cycle before output enable
            next_state  = S_RD_WAIT;
            timer_load  = 1'b1;
            timer_count = CNT_W'(READ_CYCLES + 1);
         end
         S_RD_WAIT:
            if (wait_end)
               next_state = S_IDLE;
         S_WR_SET:
         begin
            next_state  = S_WR_PULS;
            timer_load  = 1'b1;
            timer_count = (CNT_W'(WRITE_PULSE_CYCLES) > wr_total) ?
                          CNT_W'(WRITE_PULSE_CYCLES) : wr_total;
         end
         S_WR_PULS:
            if (wait_end)
               next_state = S_WR_END;
         S_WR_END:
            next_state = S_IDLE;
         default:
            next_state = S_IDLE;
      endcase
   end

   // input synchroniser for the returned byte; the wire is asynchronous
   // to clock, so only the second stage feeds the response register
   always_ff @(posedge clock)
   begin
      sync_a <= byte_lines_in;
      sync_b <= sync_a;
   end

   // marks the first edge after reset, where the power-up wait is loaded
   always_ff @(posedge clock)
   begin
      if (reset)
         power_arm <= 1'b1;
      else
         power_arm <= 1'b0;
   end

   // named sequence points, one per pin or user flag change
   wire power_exit = (state == S_POWER) && wait_end;
   wire rd_launch  = (state == S_RD_SET);
   wire rd_finish  = (state == S_RD_WAIT) && wait_end;
   wire wr_launch  = (state == S_WR_SET);
   wire wr_finish  = (state == S_WR_PULS) && wait_end;
   wire wr_release = (state == S_WR_END);
   wire next_ready = (next_state == S_IDLE) && !take;

   // state register
   always_ff @(posedge clock)
   begin
      if (reset)
         state <= S_POWER;
      else
         state <= next_state;
   end

   // user side flags; ready drops on the take edge so no second request slips in
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data  <= '0;
         init_done <= 1'b0;
      end
      else
      begin
         req_ready <= next_ready;
         rsp_valid <= rd_finish;
         if (rd_finish)
            rsp_data <= sync_b;
         if (power_exit)
            init_done <= 1'b1;
      end
   end

   // memory pins, all registered so no decode glitch reaches the wire
   always_ff @(posedge clock)
   begin
      if (reset)
      begin
         pins            <= PINS_IDLE;
         location_lines  <= '0;
         byte_lines_out  <= '0;
         byte_lines_oe_n <= 1'b1;
      end
      else
      begin
         if (take)
         begin
            location_lines <= req.address;
            byte_lines_out <= req.data;
            pins.select_active_low  <= 1'b0;
            pins.select_active_high <= 1'b1;
            // write: drive data now so setup precedes the write end
            byte_lines_oe_n <= !req.write;
         end
         if (rd_launch)
            pins.output_enable_n <= 1'b0;
         if (wr_launch)
            pins.write_enable_n <= 1'b0;
         // deselect on completion lets the device drop to standby
         if (rd_finish)
            pins <= PINS_IDLE;
         if (wr_finish)
            pins.write_enable_n <= 1'b1;
         if (wr_release)
         begin
            // data held one edge past write end, zero hold is enough
            byte_lines_oe_n <= 1'b1;
            pins            <= PINS_IDLE;
         end
      end
   end
endmodule

// [hdl/sram_host_pkg.sv]
// shared constants and carrier types for the static memory host controller
package sram_host_pkg;
   localparam int ADDR_W = 21;
   localparam int DATA_W = 8;
   localparam int CLOCK_MHZ = 50;
   localparam int CLOCK_PERIOD_NS = 20;
   // timing figures in their own units
   localparam int FIRST_ACCESS_WAIT_US = 100;
   localparam int READ_CYCLE_MIN_NS = 10;
   localparam int ADDRESS_ACCESS_DELAY_NS = 10;
   localparam int WRITE_CYCLE_MIN_NS = 10;
   localparam int WRITE_PULSE_MIN_NS = 7;
   localparam int WRITE_TURNOFF_DELAY_NS = 5;
   localparam int STANDBY_ENTRY_DELAY_NS = 10;
   // write data setup is 5.5 ns, kept in tenths of a nanosecond
   localparam int WRITE_DATA_SETUP_PS100 = 55;
   // derived cycle counts, least times rounded up, never below one
   function automatic int ceil_cycles(input int ns_x10);
      int c;
      c = (ns_x10 + CLOCK_PERIOD_NS * 10 - 1) / (CLOCK_PERIOD_NS * 10);
      return (c < 1) ? 1 : c;
   endfunction
   localparam int FIRST_ACCESS_WAIT_CYCLES = FIRST_ACCESS_WAIT_US * CLOCK_MHZ;
   localparam int READ_CYCLES = ceil_cycles(ADDRESS_ACCESS_DELAY_NS * 10);
   localparam int WRITE_PULSE_CYCLES = ceil_cycles(WRITE_PULSE_MIN_NS * 10);
   localparam int TURNAROUND_CYCLES =
      ceil_cycles(WRITE_TURNOFF_DELAY_NS * 10 + WRITE_DATA_SETUP_PS100);
   localparam int CYCLE_MIN_CYCLES = ceil_cycles(WRITE_CYCLE_MIN_NS * 10);
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

   // a request from the user side
   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] data;
   } request_t;

   // the memory control pins
   typedef struct packed {
      logic select_active_low;
      logic select_active_high;
      logic output_enable_n;
      logic write_enable_n;
   } pins_t;

   localparam pins_t PINS_IDLE = 4'b1011;
endpackage

// [tb/sram_host_assertions.sv]
// concurrent checks on the memory pins of the host controller
`timescale 1ns/10ps
module sram_host_assertions
   import sram_host_pkg::*;
#(
   parameter int FIRST_WAIT = 8
)
(
   // clock and reset
   input wire logic              clock,
   input wire logic              reset,
   // observed outputs
   input wire logic              init_done,
   input wire logic              rsp_valid,
   input wire logic [ADDR_W-1:0] location_lines,
   input wire pins_t             pins,
   input wire logic [DATA_W-1:0] byte_lines_out,
   input wire logic              byte_lines_oe_n
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   logic [15:0] age;
   wire sel = !pins.select_active_low && pins.select_active_high;
   // saturating age since reset, so the power wait can be measured
   always_ff @(posedge clock)
      if (reset)
         age <= 16'h0000;
      else if (age != 16'hFFFF)
         age <= age + 16'h0001;
   a_power_wait: assert property (init_done |-> age > FIRST_WAIT)
      else $error("ready before power wait");
   a_no_early_sel: assert property (!init_done |-> !sel)
      else $error("selected during power wait");
   a_bus_no_fight: assert property (!byte_lines_oe_n |-> pins.output_enable_n)
      else $error("both sides may drive");
   a_read_mode: assert property (!pins.output_enable_n |->
      sel && pins.write_enable_n)
      else $error("bad read pin state");
   a_write_start: assert property ($fell(pins.write_enable_n) |-> sel
      && !$past(byte_lines_oe_n) && $stable(location_lines))
      else $error("write started unprepared");
   a_write_end: assert property ($rose(pins.write_enable_n) |-> sel
      && !byte_lines_oe_n && $stable(location_lines) && $stable(byte_lines_out))
      else $error("write end not clean");
   a_read_hold: assert property ($fell(pins.output_enable_n) |->
      (!pins.output_enable_n && $stable(location_lines)) [*2])
      else $error("read cut short");
   a_read_answer: assert property ($fell(pins.output_enable_n) |->
      ##[1:12] rsp_valid)
      else $error("read never answered");
   a_addr_steady: assert property ((sel && $past(sel)) |->
      $stable(location_lines))
      else $error("address moved while selected");
   c_write: cover property ($rose(pins.write_enable_n));
   c_read: cover property (rsp_valid);
   c_init: cover property ($rose(init_done));
endmodule
bind sram_host sram_host_assertions #(.FIRST_WAIT(FIRST_WAIT)) chk_u (.clock(clock),
   .reset(reset), .init_done(init_done), .rsp_valid(rsp_valid),
   .location_lines(location_lines), .pins(pins), .byte_lines_out(byte_lines_out),
   .byte_lines_oe_n(byte_lines_oe_n));

// [tb/sram_model.sv]
// behavioural static memory as seen from the wire
`timescale 1ns/10ps
module sram_model
   import sram_host_pkg::*;
(
   // memory pins from the host
   input  wire logic [ADDR_W-1:0] location_lines,
   input  wire pins_t             pins,
   input  wire logic [DATA_W-1:0] byte_lines_out,
   input  wire logic              byte_lines_oe_n,
   // wire level back to the host
   output logic [DATA_W-1:0]      byte_lines_in
);
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   logic [DATA_W-1:0] fresh;
   logic [DATA_W-1:0] shown   = 8'h00;
   logic              settled = 1'b1;
   wire sel = !pins.select_active_low && pins.select_active_high;
   wire wr  = sel && !pins.write_enable_n;
   wire rd  = sel && !pins.output_enable_n && pins.write_enable_n;
   // store what stands on the wire when the overlap ends, whichever pin ends it
   always @(negedge wr)
      mem[location_lines] = byte_lines_in;
   // byte the array would answer with
   always @*
      fresh = (rd && mem.exists(location_lines)) ? mem[location_lines] : 8'h00;
   // old byte kept 3 ns after a change, scrambled until the access time ends
   always @(fresh)
   begin
      settled <= #3 1'b0;
      settled <= #10 1'b1;
      shown   <= #10 fresh;
   end
   // a floating wire shows the inverse of the last byte, never a kind value
   always @*
      if (!byte_lines_oe_n)
         byte_lines_in = byte_lines_out;
      else if (rd && settled)
         byte_lines_in = shown;
      else
         byte_lines_in = ~shown;
endmodule

// [tb/tb_sram_host.sv]
// self-checking bench for the static memory host controller
`timescale 1ns/10ps
module tb_sram_host;
   import sram_host_pkg::*;
   localparam int WAIT  = 8;
   localparam int LIMIT = 60;
   logic              clock = 0;
   logic              reset = 1;
   logic              req_valid = 0;
   request_t          req = '0;
   logic              req_ready, rsp_valid, init_done, byte_lines_oe_n;
   logic [DATA_W-1:0] rsp_data, byte_lines_out, byte_lines_in, q;
   logic [ADDR_W-1:0] location_lines;
   pins_t             pins;
   int                miscompares = 0;
   int                samples_checked = 0;
   always #10 clock = ~clock;
   sram_host #(.FIRST_WAIT(WAIT)) dut_u (.clock(clock), .reset(reset), .req_valid(req_valid),
      .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .init_done(init_done), .location_lines(location_lines), .pins(pins),
      .byte_lines_out(byte_lines_out), .byte_lines_oe_n(byte_lines_oe_n),
      .byte_lines_in(byte_lines_in));
   sram_model mem_u (.location_lines(location_lines), .pins(pins),
      .byte_lines_out(byte_lines_out), .byte_lines_oe_n(byte_lines_oe_n),
      .byte_lines_in(byte_lines_in));
   task automatic end_sim;
      if (miscompares == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // a used-up wait counts as a mismatch and closes the run
   task automatic timed_out(input int n, input int bound);
      if (n >= bound)
      begin
         miscompares++;
         $display("CHECK FAILED %0t wait limit reached", $time);
         end_sim;
      end
   endtask
   // one request; pins idle and bus released once it is done
   task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
      int n;
      @(negedge clock);
      req_valid = 1;
      req = '{wr, a, d};
      for (n = 0; n < LIMIT && req_ready !== 1; n++)
         @(negedge clock);
      timed_out(n, LIMIT);
      @(negedge clock);
      req_valid = 0;
      for (n = 0; n < LIMIT && (wr ? req_ready !== 1 : rsp_valid !== 1); n++)
         @(negedge clock);
      timed_out(n, LIMIT);
      q = rsp_data;
      check(pins, PINS_IDLE);
      check(byte_lines_oe_n, 1);
   endtask
   // releases reset and times the power wait; lines idle meanwhile
   task automatic power_wait;
      int n;
      reset = 0;
      for (n = 0; n < 200 && init_done !== 1; n++)
      begin
         check(pins, PINS_IDLE);
         @(negedge clock);
      end
      timed_out(n, 200);
      check(n >= WAIT, 1);
      check(req_ready, 1);
   endtask
   task automatic t_power;
      repeat (10) @(negedge clock);
      power_wait;
   endtask
   // reset lands right after a write is taken; the write must never happen
   task automatic t_reset;
      int n;
      @(negedge clock);
      req_valid = 1;
      req = '{1'b1, 21'h0A_5A5A, 8'h99};
      for (n = 0; n < LIMIT && req_ready !== 1; n++)
         @(negedge clock);
      timed_out(n, LIMIT);
      @(negedge clock);
      req_valid = 0;
      reset = 1;
      repeat (3) @(negedge clock);
      check(pins, PINS_IDLE);
      check(byte_lines_oe_n, 1);
      check(init_done, 0);
      power_wait;
      access(1'b0, 21'h0A_5A5A, 8'h00);
      check(q, 8'h3C);
   endtask
   // two boundary locations and one mid location written, read back, then location 0 overwritten and read back to back
   task automatic t_rw;
      logic [ADDR_W-1:0] a [3] = '{21'h00_0000, 21'h1F_FFFF, 21'h0A_5A5A};
      logic [DATA_W-1:0] d [3] = '{8'h5A, 8'hA5, 8'h3C};
      for (int i = 0; i < 3; i++)
         access(1'b1, a[i], d[i]);
      for (int i = 0; i < 3; i++)
      begin
         access(1'b0, a[i], 8'h00);
         check(q, d[i]);
      end
      access(1'b1, a[0], 8'hC3);
      access(1'b0, a[0], 8'h00);
      check(q, 8'hC3);
   endtask
   initial
   begin
      t_power;
      t_rw;
      t_reset;
      end_sim;
   end
endmodule
